// [hdl/sfr_map_pkg.sv]
// constants for the special function register decode block
// assumes one 125 MHz clock shared with the processor core and its peripherals
// Notes on behaviour
// RULE_01 - registers live at 80h-FFh, direct addressing only
// RULE_02 - bit access only where low nibble 0h/8h
// RULE_03 - protected setup registers writable only in safe mode
// RULE_04 - alias names share one storage byte
// RULE_05 - shared address splits by direction or mode
// RULE_06 - extended bank 2440h-298Fh, paged 40h-8Fh too
// RULE_07 - all standard core registers plus peripheral registers
// RULE_08 - shared address: write key, read part identifier
// RULE_09 - software unlocks safe mode before protected writes
package sfr_map_pkg;
    localparam int SFR_DW = 8;
    localparam int XA_W = 16;
    localparam logic [7:0] SFR_FIRST = 8'h80;
    // shared and protected addresses, plus the unprotected ADDR_SPI_DIV
    localparam logic [7:0] ADDR_KEY_ID = 8'hA1;
    localparam logic [7:0] ADDR_GLOBAL = 8'hB1;
    localparam logic [7:0] ADDR_PLL = 8'hB2;
    localparam logic [7:0] ADDR_CLOCK = 8'hB3;
    localparam logic [7:0] ADDR_SLEEP = 8'hEA;
    localparam logic [7:0] ADDR_WAKE = 8'hEB;
    localparam logic [7:0] ADDR_SPI_DIV = 8'hFB;
    localparam logic [7:0] ADDR_ROM_CMD = 8'h86;
    localparam logic [7:0] ADDR_T2_LO = 8'hCC;
    localparam logic [7:0] ADDR_T2_HI = 8'hCD;
    // standard core register addresses
    localparam logic [7:0] ADDR_SP = 8'h81;
    localparam logic [7:0] ADDR_PCON = 8'h87;
    localparam logic [7:0] ADDR_P0 = 8'h80;
    localparam logic [7:0] ADDR_P1 = 8'h90;
    localparam logic [7:0] ADDR_P2 = 8'hA0;
    localparam logic [7:0] ADDR_P3 = 8'hB0;
    localparam logic [7:0] ADDR_SPI_STAT = 8'hF8;
    localparam logic [7:0] ADDR_SPI_CTRL = 8'hFA;
    localparam logic [7:0] ADDR_XBUS_SPEED = 8'hFD;
    // bit addressable low nibbles
    localparam logic [3:0] BIT_NIB_A = 4'h0;
    localparam logic [3:0] BIT_NIB_B = 4'h8;
    // extended bank
    localparam logic [15:0] EXT_FIRST = 16'h2440;
    localparam logic [15:0] EXT_LAST = 16'h298F;
    localparam logic [7:0] PDATA_FIRST = 8'h40;
    localparam logic [7:0] PDATA_LAST = 8'h8F;
    localparam logic [7:0] PDATA_PAGE = 8'h24;
    localparam int EXT_DEPTH = 1360;
    // values after reset
    localparam logic [7:0] RST_ZERO = 8'h00;
    localparam logic [7:0] RST_SP = 8'h07;
    localparam logic [7:0] RST_PORT = 8'hFF;
    localparam logic [7:0] RST_GLOBAL = 8'hC0;
    localparam logic [7:0] RST_PLL = 8'hD8;
    localparam logic [7:0] RST_CLOCK = 8'h98;
    localparam logic [7:0] RST_PCON = 8'h10;
    localparam logic [7:0] RST_SPI_DIV = 8'h20;
    localparam logic [7:0] RST_SPI_STAT = 8'h08;
    localparam logic [7:0] RST_SPI_CTRL = 8'h02;
    // safe mode unlock keys and window
    localparam logic [7:0] KEY_FIRST = 8'h55;
    localparam logic [7:0] KEY_SECOND = 8'hAA;
    localparam int CLK_PERIOD_NS = 8;
    localparam int SAFE_WINDOW_NS = 1000;
    localparam int SAFE_CYCLES = SAFE_WINDOW_NS / CLK_PERIOD_NS;
    localparam int SAFE_CW = 8;
    typedef enum logic [1:0] {
        SAFE_LOCKED = 2'b00,
        SAFE_HALF = 2'b01,
        SAFE_OPEN = 2'b10
    } safe_state_e;
endpackage : sfr_map_pkg

// [hdl/sfr_space_decode_safe_mode.sv]
// register space decode: direct byte/bit port, extended bank port, safe mode lock
// assumes the core issues at most one request per port per cycle on mclk
`timescale 1ns/10ps
module sfr_space_decode_safe_mode #(
    parameter logic [7:0] PART_ID = 8'h3C // arbitrary identification value
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // direct register access from the core
    input wire logic [sfr_map_pkg::SFR_DW-1:0] sfr_addr,
    input wire logic sfr_rd,
    input wire logic sfr_wr,
    input wire logic sfr_indirect,
    input wire logic sfr_bit,
    input wire logic [2:0] sfr_bit_sel,
    input wire logic [sfr_map_pkg::SFR_DW-1:0] sfr_wdata,
    output logic [sfr_map_pkg::SFR_DW-1:0] sfr_rdata,
    output logic sfr_ack,
    output logic sfr_refused,
    // extended bank access
    input wire logic [sfr_map_pkg::XA_W-1:0] x_addr,
    input wire logic x_paged,
    input wire logic x_rd,
    input wire logic x_wr,
    input wire logic [sfr_map_pkg::SFR_DW-1:0] x_wdata,
    output logic [sfr_map_pkg::SFR_DW-1:0] x_rdata,
    output logic x_ack,
    output logic x_refused,
    // peripheral side views
    input wire logic [sfr_map_pkg::SFR_DW-1:0] rom_status_in,
    input wire logic [15:0] t2_cap1_in,
    input wire logic t2_cap_view,
    output logic rom_cmd_stb,
    output logic safe_mode_active,
    output logic [sfr_map_pkg::SFR_DW-1:0] global_setup_q,
    output logic [sfr_map_pkg::SFR_DW-1:0] pll_setup_q,
    output logic [sfr_map_pkg::SFR_DW-1:0] system_clock_setup_q,
    output logic [sfr_map_pkg::SFR_DW-1:0] low_power_entry_q,
    output logic [sfr_map_pkg::SFR_DW-1:0] wake_source_select_q
);
    import sfr_map_pkg::*;

    // storage for every byte of the 80h-FFh space
    logic [7:0] special_function_regs_r [128];
    logic [7:0] special_function_regs_nxt [128];
    logic [7:0] extended_function_regs [EXT_DEPTH];
    safe_state_e safe_r, safe_nxt;
    logic safe_act_r, safe_act_nxt;
    logic [SAFE_CW-1:0] safe_cnt_r, safe_cnt_nxt;
    logic [7:0] sfr_rdata_r, sfr_rdata_nxt;
    logic sfr_ack_r, sfr_ack_nxt, sfr_ref_r, sfr_ref_nxt, rom_stb_r, rom_stb_nxt;
    logic [7:0] x_rdata_r, x_rdata_nxt;
    logic x_ack_r, x_ack_nxt, x_ref_r, x_ref_nxt;
    logic x_we;
    logic [10:0] x_index;
    logic [15:0] x_full;
    logic x_hit;
    logic [6:0] idx;
    logic prot, sfr_req, sfr_ok, key_wr;
    logic [7:0] cur, wbyte;

    // the safe window must fit its down counter
    if (SAFE_CYCLES < 1 || SAFE_CYCLES > 255)
    begin : g_window_check
        $error("safe window does not fit its counter");
    end

    // value each byte takes at reset
    function automatic logic [7:0] reset_value(input logic [7:0] a);
        logic [7:0] v;
        v = RST_ZERO;
        case (a)
            ADDR_SP: v = RST_SP; // [RULE_07]
            ADDR_P0, ADDR_P1, ADDR_P2, ADDR_P3, ADDR_XBUS_SPEED: v = RST_PORT;
            ADDR_PCON: v = RST_PCON;
            ADDR_GLOBAL: v = RST_GLOBAL;
            ADDR_PLL: v = RST_PLL;
            ADDR_CLOCK: v = RST_CLOCK;
            ADDR_SPI_DIV: v = RST_SPI_DIV;
            ADDR_SPI_STAT: v = RST_SPI_STAT;
            ADDR_SPI_CTRL: v = RST_SPI_CTRL;
            default: v = RST_ZERO;
        endcase
        return v;
    endfunction : reset_value

    // direct access decode and next storage
    always_comb
    begin
        idx = sfr_addr[6:0];
        sfr_req = sfr_rd ^ sfr_wr;
        prot = (sfr_addr == ADDR_GLOBAL) || (sfr_addr == ADDR_PLL) || (sfr_addr == ADDR_CLOCK)
            || (sfr_addr == ADDR_SLEEP) || (sfr_addr == ADDR_WAKE);
        // low space and indirect access never reach these registers
        sfr_ok = sfr_req && sfr_addr[7] && !sfr_indirect; // [RULE_01]
        if (sfr_bit && sfr_addr[3:0] != BIT_NIB_A && sfr_addr[3:0] != BIT_NIB_B)
        begin
            sfr_ok = 1'b0; // [RULE_02]
        end
        if (sfr_wr && prot && safe_r != SAFE_OPEN)
        begin
            sfr_ok = 1'b0; // [RULE_03]
        end
        key_wr = sfr_ok && sfr_wr && sfr_addr == ADDR_KEY_ID; // [RULE_08]
        // read side selects the register that answers at a shared address
        case (sfr_addr)
            ADDR_KEY_ID: cur = PART_ID; // [RULE_08]
            ADDR_ROM_CMD: cur = sfr_wr ? special_function_regs_r[idx] : rom_status_in; // [RULE_05]
            ADDR_T2_LO: cur = t2_cap_view ? t2_cap1_in[7:0] : special_function_regs_r[idx]; // [RULE_05]
            ADDR_T2_HI: cur = t2_cap_view ? t2_cap1_in[15:8] : special_function_regs_r[idx]; // [RULE_05]
            default: cur = special_function_regs_r[idx]; // [RULE_04] [RULE_07]
        endcase
        wbyte = special_function_regs_r[idx];
        if (sfr_bit)
        begin
            wbyte[sfr_bit_sel] = sfr_wdata[0]; // single bit merge
        end
        else
        begin
            wbyte = sfr_wdata;
        end
        for (int i = 0; i < 128; i++)
        begin
            special_function_regs_nxt[i] = special_function_regs_r[i];
        end
        if (sfr_ok && sfr_wr && !key_wr)
        begin
            special_function_regs_nxt[idx] = wbyte;
        end
        sfr_ack_nxt = sfr_rd | sfr_wr;
        sfr_ref_nxt = (sfr_rd | sfr_wr) && !sfr_ok;
        rom_stb_nxt = sfr_ok && sfr_wr && sfr_addr == ADDR_ROM_CMD; // [RULE_05]
        sfr_rdata_nxt = sfr_rdata_r;
        if (sfr_ok && sfr_rd)
        begin
            sfr_rdata_nxt = sfr_bit ? {7'b0, cur[sfr_bit_sel]} : cur;
        end
    end

    // safe mode key sequence and open window
    always_comb
    begin
        safe_nxt = safe_r;
        safe_cnt_nxt = safe_cnt_r;
        case (safe_r)
            SAFE_LOCKED:
            begin
                if (key_wr && sfr_wdata == KEY_FIRST)
                begin
                    safe_nxt = SAFE_HALF;
                end
            end
            SAFE_HALF:
            begin
                if (key_wr)
                begin
                    safe_nxt = (sfr_wdata == KEY_SECOND) ? SAFE_OPEN : SAFE_LOCKED; // [RULE_09]
                    safe_cnt_nxt = SAFE_CW'(SAFE_CYCLES);
                end
            end
            SAFE_OPEN:
            begin
                safe_cnt_nxt = safe_cnt_r - SAFE_CW'(1);
                if (safe_cnt_r == SAFE_CW'(1) || (key_wr && sfr_wdata != KEY_FIRST))
                begin
                    safe_nxt = SAFE_LOCKED; // window closes
                end
            end
            default: safe_nxt = SAFE_LOCKED;
        endcase
        safe_act_nxt = (safe_nxt == SAFE_OPEN); // flag kept in a flop so the output is glitch free
    end

    // extended bank decode, paged addresses fold into the same bytes
    always_comb
    begin
        x_full = x_paged ? {PDATA_PAGE, x_addr[7:0]} : x_addr; // [RULE_06]
        x_hit = x_paged ? (x_addr[7:0] >= PDATA_FIRST && x_addr[7:0] <= PDATA_LAST && x_addr[15:8] == 8'h00)
            : (x_addr >= EXT_FIRST && x_addr <= EXT_LAST); // [RULE_06]
        x_index = 11'(x_full - EXT_FIRST);
        x_we = x_hit && x_wr && !x_rd;
        x_ack_nxt = x_rd | x_wr;
        x_ref_nxt = (x_rd | x_wr) && !(x_hit && (x_rd ^ x_wr));
        x_rdata_nxt = x_rdata_r;
        if (x_hit && x_rd && !x_wr)
        begin
            x_rdata_nxt = extended_function_regs[x_index];
        end
    end

    // control registers
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            for (int i = 0; i < 128; i++)
            begin
                special_function_regs_r[i] <= reset_value(8'(i) | SFR_FIRST);
            end
            safe_r <= SAFE_LOCKED;
            safe_cnt_r <= '0;
            safe_act_r <= 1'b0;
            sfr_rdata_r <= RST_ZERO;
            sfr_ack_r <= 1'b0;
            sfr_ref_r <= 1'b0;
            rom_stb_r <= 1'b0;
            x_rdata_r <= RST_ZERO;
            x_ack_r <= 1'b0;
            x_ref_r <= 1'b0;
        end
        else
        begin
            special_function_regs_r <= special_function_regs_nxt;
            safe_r <= safe_nxt;
            safe_cnt_r <= safe_cnt_nxt;
            safe_act_r <= safe_act_nxt;
            sfr_rdata_r <= sfr_rdata_nxt;
            sfr_ack_r <= sfr_ack_nxt;
            sfr_ref_r <= sfr_ref_nxt;
            rom_stb_r <= rom_stb_nxt;
            x_rdata_r <= x_rdata_nxt;
            x_ack_r <= x_ack_nxt;
            x_ref_r <= x_ref_nxt;
        end
    end

    // extended bank memory, no reset
    always_ff @(posedge mclk)
    begin
        if (x_we)
        begin
            extended_function_regs[x_index] <= x_wdata;
        end
    end

    // outputs straight from flops
    assign sfr_rdata = sfr_rdata_r;
    assign sfr_ack = sfr_ack_r;
    assign sfr_refused = sfr_ref_r;
    assign x_rdata = x_rdata_r;
    assign x_ack = x_ack_r;
    assign x_refused = x_ref_r;
    assign rom_cmd_stb = rom_stb_r;
    assign safe_mode_active = safe_act_r;
    assign global_setup_q = special_function_regs_r[ADDR_GLOBAL[6:0]];
    assign pll_setup_q = special_function_regs_r[ADDR_PLL[6:0]];
    assign system_clock_setup_q = special_function_regs_r[ADDR_CLOCK[6:0]];
    assign low_power_entry_q = special_function_regs_r[ADDR_SLEEP[6:0]];
    assign wake_source_select_q = special_function_regs_r[ADDR_WAKE[6:0]];
endmodule : sfr_space_decode_safe_mode

// [sim/sfr_chk_assertions.sv]
// assertions on the direct register port, the refusals and the safe mode lock
// assumes binding to the decode block's top module, one clock, async reset
`timescale 1ns/10ps
module sfr_chk #(
    parameter logic [7:0] PART_ID = 8'h3C
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // direct port
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_rd,
    input wire logic sfr_wr,
    input wire logic sfr_indirect,
    input wire logic sfr_bit,
    input wire logic [7:0] sfr_wdata,
    input wire logic [7:0] sfr_rdata,
    input wire logic sfr_ack,
    input wire logic sfr_refused,
    // side views
    input wire logic rom_cmd_stb,
    input wire logic safe_mode_active,
    input wire logic [7:0] global_setup_q
);
    import sfr_map_pkg::*;
    // plain byte write and plain direct read
    wire logic req = sfr_rd | sfr_wr;
    wire logic wr1 = sfr_wr & ~sfr_rd & ~sfr_indirect & ~sfr_bit;
    wire logic rd1 = sfr_rd & ~sfr_wr & ~sfr_indirect;
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);
    // unlock: first key then second key on back-to-back cycles
    sequence key_pair;
        wr1 && sfr_addr == ADDR_KEY_ID && sfr_wdata == KEY_FIRST ##1
        wr1 && sfr_addr == ADDR_KEY_ID && sfr_wdata == KEY_SECOND;
    endsequence
    // refusals, safe mode opening and shared addresses
    low_addr_refused_a: assert property (req && !sfr_addr[7] |=> sfr_ack && sfr_refused)
        else $error("request below the map not refused");
    indirect_refused_a: assert property (req && sfr_indirect |=> sfr_refused)
        else $error("indirect access not refused");
    bit_nibble_refused_a: assert property (req && sfr_bit && sfr_addr[2:0] != 3'h0 |=> sfr_refused)
        else $error("bit access off a bit column not refused");
    bit_read_taken_a: assert property (rd1 && sfr_bit && sfr_addr[7] && sfr_addr[2:0] == 3'h0
        |=> sfr_ack && !sfr_refused) else $error("bit read on a bit column refused");
    locked_write_held_a: assert property (wr1 && sfr_addr == ADDR_GLOBAL && !safe_mode_active
        |=> sfr_refused && $stable(global_setup_q)) else $error("locked setup write took effect");
    safe_open_a: assert property (key_pair |=> safe_mode_active)
        else $error("key pair did not open safe mode");
    part_id_read_a: assert property (rd1 && !sfr_bit && sfr_addr == ADDR_KEY_ID |=> sfr_rdata == PART_ID)
        else $error("shared key address did not read the identifier");
    rom_cmd_pulse_a: assert property (wr1 && sfr_addr == ADDR_ROM_CMD |=> rom_cmd_stb)
        else $error("command write gave no strobe");
endmodule : sfr_chk
bind sfr_space_decode_safe_mode sfr_chk #(.PART_ID(PART_ID)) u_sfr_chk (.mclk, .rst, .sfr_addr, .sfr_rd, .sfr_wr,
    .sfr_indirect, .sfr_bit, .sfr_wdata, .sfr_rdata, .sfr_ack, .sfr_refused, .rom_cmd_stb, .safe_mode_active,
    .global_setup_q);

// [sim/core_port.sv]
// core model: issues direct register requests and the safe mode unlock
// assumes the block answers on the taking edge itself, read back 1 ns after it
`timescale 1ns/10ps
module core_port (
    // clock
    input wire logic mclk,
    // requests
    output logic [7:0] sfr_addr,
    output logic sfr_rd,
    output logic sfr_wr,
    output logic sfr_indirect,
    output logic sfr_bit,
    output logic [7:0] sfr_wdata,
    // answers
    input wire logic [7:0] sfr_rdata,
    input wire logic sfr_ack,
    input wire logic sfr_refused
);
    import sfr_map_pkg::*;
    // idle at time zero
    initial
    begin
        {sfr_rd, sfr_wr, sfr_indirect, sfr_bit} = 4'h0;
        sfr_addr = 8'h00;
        sfr_wdata = 8'h00;
    end
    // one request held to its taking edge, then released with inverted lines
    task automatic op(input logic [3:0] kind, input logic [7:0] a, input logic [7:0] d, output logic [9:0] res);
        @(posedge mclk);
        {sfr_rd, sfr_wr, sfr_indirect, sfr_bit} <= kind;
        sfr_addr <= a;
        sfr_wdata <= d;
        @(posedge mclk);
        {sfr_rd, sfr_wr, sfr_indirect, sfr_bit} <= 4'h0;
        sfr_addr <= ~a;
        sfr_wdata <= ~d;
        #1;
        res = {sfr_ack, sfr_refused, sfr_rdata};
    endtask : op
    // two key writes on back-to-back cycles open the protected window
    task automatic unlock();
        @(posedge mclk);
        {sfr_rd, sfr_wr, sfr_indirect, sfr_bit} <= 4'b0100;
        sfr_addr <= ADDR_KEY_ID;
        sfr_wdata <= KEY_FIRST;
        @(posedge mclk);
        sfr_wdata <= KEY_SECOND;
        @(posedge mclk);
        sfr_wr <= 1'b0;
    endtask : unlock
endmodule : core_port

// [sim/testbench.sv]
// testbench: core model plus a reference byte map compared at each accepted direct byte read
// assumes the checker is bound in from its own file
`timescale 1ns/10ps
module testbench;
    import sfr_map_pkg::*;
    localparam logic [7:0] ID_VAL = 8'h5A; // arbitrary identifier value
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, x_rdata;
    logic sfr_rd, sfr_wr, sfr_indirect, sfr_bit, sfr_ack, sfr_refused, x_ack, x_refused, rom_cmd_stb;
    logic [7:0] rom_status_in = 8'h00, x_wdata = 8'h00;
    logic [15:0] x_addr = 16'h0000, t2_cap1_in = 16'h0000;
    logic x_paged = 1'b0, x_rd = 1'b0, x_wr = 1'b0, t2_cap_view = 1'b0;
    logic [2:0] bit_sel = 3'h0;
    logic [9:0] res;
    logic [31:0] lfsr = 32'h1f7b_1d69;
    logic [15:0] rst_tab [12] = '{16'hB1C0, 16'hB2D8, 16'hB398, 16'hEA00, 16'hEB00, 16'h8107, 16'h80FF,
        16'hFB20, 16'hF808, 16'hFA02, 16'hFDFF, 16'h8710};
    logic [7:0] prot [5] = '{ADDR_GLOBAL, ADDR_PLL, ADDR_CLOCK, ADDR_SLEEP, ADDR_WAKE};
    logic [3:0] rf_kind [5] = '{4'b1000, 4'b1010, 4'b1001, 4'b1100, 4'b1001};
    logic [7:0] rf_addr [5] = '{8'h7F, 8'h90, 8'h81, 8'h90, 8'h90};
    logic [1:0] rf_st [5] = '{2'b11, 2'b11, 2'b11, 2'b11, 2'b10};
    int model[int];
    int mismatches = 0, num_checks = 0;
    // clock
    always #4 mclk = ~mclk;
    // block under test and core model
    sfr_space_decode_safe_mode #(.PART_ID(ID_VAL)) u_sfr_space_decode_safe_mode (.mclk, .rst, .sfr_addr, .sfr_rd,
        .sfr_wr, .sfr_indirect, .sfr_bit, .sfr_bit_sel(bit_sel), .sfr_wdata, .sfr_rdata, .sfr_ack, .sfr_refused, .x_addr,
        .x_paged, .x_rd, .x_wr, .x_wdata, .x_rdata, .x_ack, .x_refused, .rom_status_in, .t2_cap1_in, .t2_cap_view,
        .rom_cmd_stb, .safe_mode_active(), .global_setup_q(), .pll_setup_q(), .system_clock_setup_q(),
        .low_power_entry_q(), .wake_source_select_q());
    core_port u_core_port (.mclk, .sfr_addr, .sfr_rd, .sfr_wr, .sfr_indirect, .sfr_bit, .sfr_wdata, .sfr_rdata,
        .sfr_ack, .sfr_refused);
    // helpers: random source, compare, verdict, byte access, extended access
    function automatic logic [31:0] next_rand(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : next_rand
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic give_verdict();
        if (mismatches == 0 && num_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : give_verdict
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] st);
        u_core_port.op(4'b0100, a, d, res);
        chk("write status", 16'(res[9:8]), 16'(st));
        if (st == 2'b10)
            model[a] = d;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        u_core_port.op(4'b1000, a, 8'h00, res);
        chk("read", 16'(res), {6'h00, 2'b10, 8'(model[a])});
    endtask : rd
    task automatic xop(input logic r, input logic p, input logic [15:0] a, input logic [7:0] d, input logic [9:0] e);
        @(posedge mclk);
        {x_rd, x_wr, x_paged, x_addr, x_wdata} <= {r, ~r, p, a, d};
        @(posedge mclk);
        {x_rd, x_wr, x_addr, x_wdata} <= {2'b00, ~a, ~d};
        #1;
        chk("extended", 16'({x_ack, x_refused, r ? x_rdata : 8'h00}), 16'(e));
    endtask : xop
    // main sequence
    initial
    begin
        repeat (10) @(posedge mclk);
        rst <= 1'b0;
        for (int i = 0; i < 12; i++)
        begin
            model[rst_tab[i][15:8]] = rst_tab[i][7:0];
            rd(rst_tab[i][15:8]);
        end
        model[ADDR_KEY_ID] = ID_VAL;
        u_core_port.op(4'b0100, ADDR_KEY_ID, 8'h00, res);
        rd(ADDR_KEY_ID);
        for (int p = 0; p < 2; p++)
        begin
            if (p == 1)
                u_core_port.unlock();
            for (int j = 0; j < 5; j++)
            begin
                lfsr = next_rand(lfsr);
                wr(prot[j], lfsr[7:0], p ? 2'b10 : 2'b11);
                rd(prot[j]);
            end
        end
        repeat (130) @(posedge mclk);
        wr(ADDR_PLL, 8'h11, 2'b11);
        wr(ADDR_SPI_DIV, lfsr[15:8], 2'b10);
        rd(ADDR_SPI_DIV);
        @(posedge mclk);
        rom_status_in <= lfsr[23:16];
        t2_cap1_in <= lfsr[31:16];
        t2_cap_view <= 1'b1;
        wr(ADDR_ROM_CMD, 8'h5C, 2'b10);
        model[ADDR_ROM_CMD] = lfsr[23:16];
        model[ADDR_T2_LO] = lfsr[23:16];
        model[ADDR_T2_HI] = lfsr[31:24];
        rd(ADDR_ROM_CMD);
        rd(ADDR_T2_LO);
        rd(ADDR_T2_HI);
        // with the capture view off the timer byte itself answers
        @(posedge mclk);
        t2_cap_view <= 1'b0;
        wr(ADDR_T2_LO, lfsr[7:0], 2'b10);
        rd(ADDR_T2_LO);
        for (int j = 0; j < 5; j++)
        begin
            u_core_port.op(rf_kind[j], rf_addr[j], 8'h00, res);
            chk("refusal", 16'(res[9:8]), 16'(rf_st[j]));
        end
        chk("bit read", 16'(res[7:0]), 16'h0001);
        // single bit write clears a random bit of a bit column byte
        @(posedge mclk);
        bit_sel <= lfsr[2:0];
        model[8'h90] = 8'hFF & ~(8'h01 << lfsr[2:0]);
        u_core_port.op(4'b0101, 8'h90, 8'h00, res);
        chk("bit write", 16'(res[9:8]), 16'h0002);
        rd(8'h90);
        xop(1'b0, 1'b0, 16'h2450, lfsr[7:0], {2'b10, 8'h00});
        xop(1'b1, 1'b1, 16'h0050, 8'h00, {2'b10, lfsr[7:0]});
        xop(1'b0, 1'b0, 16'h298F, lfsr[15:8], {2'b10, 8'h00});
        xop(1'b1, 1'b0, 16'h298F, 8'h00, {2'b10, lfsr[15:8]});
        xop(1'b1, 1'b0, 16'h2990, 8'h00, {2'b11, lfsr[15:8]});
        xop(1'b1, 1'b1, 16'h0150, 8'h00, {2'b11, lfsr[15:8]});
        give_verdict();
    end
    // watchdog well past the few hundred cycles the sequence needs
    initial
    begin
        #100000;
        mismatches++;
        give_verdict();
    end
endmodule : testbench
